// ---- zero_overhead_loop_sequencer.v ----
// Zero-overhead loop sequencer: holds start, end and count, steers next PC.
// Assumes decode gives one-cycle op strobes, and instr_done pulses once per executed instruction.
`timescale 1ns/1ps
`default_nettype none
`include "loop_seq_defs.vh"
module zero_overhead_loop_sequencer
(
  // Clock and reset
  input  wire                clk,
  input  wire                nrst,
  // Repeat operations from decode
  input  wire                block_repeat_op,
  input  wire                single_repeat_op,
  input  wire                rel_mode,
  input  wire [`REL_W-1:0]   rel_operand,
  input  wire [`ADDR_W-1:0]  reg_operand,
  input  wire [`DATA_W-1:0]  src_count,
  input  wire [`ADDR_W-1:0]  op_pc,
  // Execution progress
  input  wire                instr_done,
  input  wire [`ADDR_W-1:0]  pc,
  input  wire [`DATA_W-1:0]  fetched_word,
  // Software writes
  input  wire                count_wr,
  input  wire [`DATA_W-1:0]  count_wr_data,
  input  wire                status_wr,
  input  wire [`ST_W-1:0]    status_wr_data,
  // Sequencing results
  output reg                 pc_load,
  output reg  [`ADDR_W-1:0]  pc_next,
  output wire                fetch_from_ir,
  output reg  [`DATA_W-1:0]  held_instruction_reg,
  output wire                irq_allow,
  output wire                setup_busy,
  // Visible state
  output reg  [`ADDR_W-1:0]  loop_start_addr,
  output reg  [`ADDR_W-1:0]  loop_end_addr,
  output reg  [`DATA_W-1:0]  loop_count,
  output reg  [`ST_W-1:0]    status_word,
  output reg                 single_flag
);

  // ---------------------------------------------------------------
  // Setup counter and state
  // ---------------------------------------------------------------
  localparam S_IDLE  = 2'h0;
  localparam S_SETUP = 2'h1;
  localparam S_RUN   = 2'h2;

  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [2:0] setup_reg;
  reg        first_pass_reg;

  wire       loop_active_flag = status_word[`ST_ACTIVE];
  wire       at_end;
  wire       order_ok;
  wire       any_op   = block_repeat_op | single_repeat_op;
  wire [`DATA_W-1:0] count_dec = loop_count - `CNT_ONE;
  wire       dec_neg  = count_dec[`CNT_SIGN];
  wire       blk_mode = loop_active_flag & ~single_flag;
  wire       sgl_mode = loop_active_flag &  single_flag;
  wire       step     = instr_done & (state_reg == S_RUN);

  loop_end_match u_match
  (
    .pc         (pc),
    .start_addr (loop_start_addr),
    .end_addr   (loop_end_addr),
    .at_end     (at_end),
    .order_ok   (order_ok)
  );

  assign setup_busy    = (state_reg == S_SETUP);
  assign fetch_from_ir = sgl_mode & ~first_pass_reg;
  assign irq_allow     = ~sgl_mode;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:  if (any_op) state_next = S_SETUP;
      S_SETUP: if (setup_reg == `SETUP_CYCLES - 3'h1) state_next = S_RUN;
      S_RUN:   if (any_op) state_next = S_SETUP;
               else if (!loop_active_flag) state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= S_IDLE;
      setup_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == S_SETUP)
        setup_reg <= setup_reg + 3'h1;
      else
        setup_reg <= 3'h0;
    end
  end

  // ---------------------------------------------------------------
  // Next PC steering
  // ---------------------------------------------------------------
  always @*
  begin
    pc_load = 1'b0;
    pc_next = pc + `ADDR_ONE;
    if (step && sgl_mode)
    begin
      if (dec_neg)
        pc_load = 1'b1;
      else
      begin
        pc_load = 1'b1;
        pc_next = pc;
      end
    end
    else if (step && blk_mode && at_end && order_ok)
    begin
      pc_load = 1'b1;
      if (!dec_neg)
        pc_next = loop_start_addr;
    end
  end

  // ---------------------------------------------------------------
  // Loop registers
  // ---------------------------------------------------------------
  wire st_set_ok = (loop_count != `CNT_ZERO) && (loop_count != `CNT_MONE);

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      loop_start_addr      <= {`ADDR_W{1'b0}};
      loop_end_addr        <= {`ADDR_W{1'b0}};
      loop_count           <= `CNT_ZERO;
      status_word          <= {`ST_W{1'b0}};
      single_flag          <= 1'b0;
      first_pass_reg       <= 1'b0;
      held_instruction_reg <= {`DATA_W{1'b0}};
    end
    else if (block_repeat_op)
    begin
      loop_start_addr          <= op_pc + `ADDR_ONE;
      loop_end_addr            <= rel_mode ? (op_pc + `ADDR_ONE + rel_operand)
                                           : reg_operand;
      status_word[`ST_ACTIVE]  <= 1'b1;
      single_flag              <= 1'b0;
      first_pass_reg           <= 1'b0;
    end
    else if (single_repeat_op)
    begin
      loop_start_addr          <= op_pc + `ADDR_ONE;
      loop_end_addr            <= op_pc + `ADDR_ONE;
      status_word[`ST_ACTIVE]  <= 1'b1;
      single_flag              <= 1'b1;
      loop_count               <= src_count;
      first_pass_reg           <= 1'b1;
    end
    else if (status_wr)
    begin
      status_word <= {status_wr_data[`ST_W-1:`ST_ACTIVE+1],
                      status_wr_data[`ST_ACTIVE] & (st_set_ok | loop_active_flag),
                      status_wr_data[`ST_ACTIVE-1:0]};
      if (!status_wr_data[`ST_ACTIVE])
        single_flag <= 1'b0;
      if (count_wr)
        loop_count <= count_wr_data;
    end
    else if (count_wr)
    begin
      loop_count <= count_wr_data;
      if (count_wr_data == `CNT_ZERO && loop_active_flag && !single_flag)
        loop_count <= `CNT_ZERO;
    end
    else if (step && sgl_mode)
    begin
      if (first_pass_reg)
        held_instruction_reg <= fetched_word;
      first_pass_reg <= 1'b0;
      loop_count     <= count_dec;
      if (dec_neg)
      begin
        status_word[`ST_ACTIVE] <= 1'b0;
        single_flag             <= 1'b0;
      end
    end
    else if (step && blk_mode && at_end && order_ok)
    begin
      loop_count <= count_dec;
      if (dec_neg)
      begin
        status_word[`ST_ACTIVE] <= 1'b0;
        single_flag             <= 1'b0;
      end
    end
    // Otherwise the count holds, including whenever loop-active is clear
  end

endmodule // zero_overhead_loop_sequencer
`default_nettype wire

// ---- loop_seq_defs.vh ----
// Constants for the zero-overhead loop sequencer.
// Assumes inclusion by bare name from the sequencer files.
//
// Overview of operation
// - After each instruction, compare end address with PC; match and decremented count>=0 loops back.
// - Loop sequencing never touches the count while the loop-active flag is clear.
// - The loop runs one more time than the count held at entry.
// - Counts up to 8000 0000h work; a count of zero gives one pass.
// - End below start never jumps back, yet the loop-active flag stays set.
// - Writing zero to the count or clearing the flag stops the loop early.
// - Single repeat fetches from memory once, then replays the held word.
// - Interrupts are blocked while a single repeat runs.
// - Single repeat decrements per pass; negative count clears flags, PC steps by one.
// - Block repeat fetches memory; at end decrement and jump or exit and step.
// - Block repeat leaves the count alone; software loads it beforehand.
// - Interrupts may be taken during block repeat.
// - Block repeat loads the start address with the address after it.
// - End address is start plus 24-bit operand, or a source register.
// - Block repeat sets loop-active and clears single-repeat.
// - Single repeat sets start and end to PC+1, both flags, count from operand.
// - Single repeat runs the next instruction operand plus one times.
// - Active with single clear is block repeat; both set is single repeat.
// - Both repeat operations take four setup cycles; later passes cost none.
// - Status writes cannot set loop-active while count is zero or minus one.
`ifndef LOOP_SEQ_DEFS_VH
`define LOOP_SEQ_DEFS_VH
`define ADDR_W       24
`define DATA_W       32
`define REL_W        24
`define SETUP_CYCLES 3'h4
`define ADDR_ONE     24'h000001
`define CNT_ZERO     32'h00000000
`define CNT_MONE     32'hFFFFFFFF
`define CNT_ONE      32'h00000001
`define CNT_SIGN     31
`define ST_W         16
`define ST_ACTIVE    8
`endif

// ---- loop_end_match.v ----
// End-of-block comparator for the loop sequencer.
// Assumes addresses are on the core clock and stable through the compare.
`timescale 1ns/1ps
`default_nettype none
`include "loop_seq_defs.vh"
module loop_end_match
(
  // Addresses
  input  wire [`ADDR_W-1:0] pc,
  input  wire [`ADDR_W-1:0] start_addr,
  input  wire [`ADDR_W-1:0] end_addr,
  // Results
  output wire               at_end,
  output wire               order_ok
);
  assign at_end   = (pc == end_addr);
  assign order_ok = (end_addr >= start_addr);
endmodule // loop_end_match
`default_nettype wire

// ---- loop_fetch_model.sv ----
// Fetch model: program counter and memory word source for the sequencer.
// Assumes the bench raises instr_done once per executed instruction.
`timescale 1ns/1ps
`default_nettype none
module loop_fetch_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Sequencer side
  input  wire logic        op_go,
  input  wire logic        instr_done,
  input  wire logic        pc_load,
  input  wire logic [23:0] pc_next,
  output var  logic [23:0] pc,
  output var  logic [31:0] fetched_word
);
  logic [7:0] tick_reg;
  // Word changes every cycle so a stale replay shows up
  assign fetched_word = {tick_reg, pc};
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      pc <= 24'h000010;
      tick_reg <= 8'h00;
    end
    else
    begin
      tick_reg <= tick_reg + 8'h01;
      if (op_go)
        pc <= pc + 24'h000001;
      else if (instr_done)
        pc <= pc_load ? pc_next : pc + 24'h000001;
    end
endmodule // loop_fetch_model
`default_nettype wire

// ---- zero_overhead_loop_sequencer_assertions.sv ----
// Concurrent checks on the loop sequencer ports.
// Assumes one core clock and nrst, asynchronous and active low.
`timescale 1ns/1ps
`default_nettype none
module loop_seq_checker
(
  // Clock, reset and operations
  input wire logic        clk, nrst, block_repeat_op, single_repeat_op, instr_done,
  input wire logic [23:0] op_pc, pc,
  // Sequencer outputs
  input wire logic        pc_load, irq_allow, setup_busy, single_flag,
  input wire logic [23:0] pc_next, loop_start_addr, loop_end_addr,
  input wire logic [31:0] loop_count,
  input wire logic [15:0] status_word
);
  wire act = status_word[8];
  wire go = block_repeat_op || single_repeat_op;
  wire run = instr_done && !setup_busy && act && pc == loop_end_addr
             && loop_start_addr <= loop_end_addr;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_loop_back: assert property (
    run && loop_count != 0 && !loop_count[31] |-> pc_load && pc_next == loop_start_addr
    ##1 loop_count == $past(loop_count) - 1) else $error("no loop back");
  a_loop_exit: assert property (
    run && loop_count == 0 |-> pc_next == pc + 24'h000001 ##1 !act && !single_flag)
    else $error("bad loop exit");
  a_block_op: assert property (
    block_repeat_op |=> act && !single_flag && loop_start_addr == $past(op_pc) + 24'h000001)
    else $error("bad block setup");
  a_single_op: assert property (
    single_repeat_op && !block_repeat_op |=> act && single_flag
    && loop_end_addr == loop_start_addr && loop_end_addr == $past(op_pc) + 24'h000001)
    else $error("bad single setup");
  a_setup_len: assert property (go |=> setup_busy [*4]) else $error("setup short");
  a_setup_end: assert property (
    go ##1 !go [*4] |=> !setup_busy) else $error("setup long");
  a_irq_block: assert property (act && single_flag |-> !irq_allow) else $error("irq open");
  a_irq_open: assert property (act && !single_flag |-> irq_allow) else $error("irq shut");
  c_block: cover property (block_repeat_op);
  c_single: cover property (run && single_flag);
  c_exit: cover property (run && loop_count == 0);
endmodule // loop_seq_checker
bind zero_overhead_loop_sequencer loop_seq_checker chk_u (.*);
`default_nettype wire

// ---- zero_overhead_loop_sequencer_tb_top.sv ----
// Self-checking bench for the loop sequencer with a fetch model.
// Assumes the design and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module zero_overhead_loop_sequencer_tb_top;
  logic        clk, nrst, block_repeat_op, single_repeat_op, rel_mode, instr_done;
  logic        count_wr, status_wr, pc_load, fetch_from_ir, irq_allow, setup_busy, single_flag;
  logic [23:0] rel_operand, reg_operand, op_pc, pc, pc_next, loop_start_addr, loop_end_addr;
  logic [31:0] src_count, fetched_word, count_wr_data, held_instruction_reg, loop_count;
  logic [31:0] seed = 32'h3455, first_w, r, passes;
  logic [15:0] status_wr_data, status_word;
  int          n_fail, samples_checked;
  zero_overhead_loop_sequencer dut_u (.*);
  loop_fetch_model fm_u (.clk(clk), .nrst(nrst), .op_go(block_repeat_op | single_repeat_op),
    .instr_done(instr_done), .pc_load(pc_load), .pc_next(pc_next), .pc(pc),
    .fetched_word(fetched_word));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Sets up one repeat and runs it to its exit
  task automatic run(input logic s, input logic [31:0] c, input logic [23:0] len);
    passes = 0;
    count_wr <= !s;
    count_wr_data <= c;
    @(posedge clk);
    count_wr <= 1'b0;
    {op_pc, src_count, rel_mode, rel_operand, reg_operand} <= {pc, c, len[0], len - 24'h1, pc + len};
    {block_repeat_op, single_repeat_op} <= {!s, s};
    @(posedge clk);
    {block_repeat_op, single_repeat_op} <= 2'h0;
    repeat (5) @(posedge clk);
    instr_done <= 1'b1;
    for (int k = 0; k < 300; k++)
    begin
      @(negedge clk);
      if (!status_word[8])
        break;
      chk(irq_allow, !s);
      if (pc == loop_end_addr)
        passes++;
      chk(fetch_from_ir, s && passes > 1);
      if (s && passes == 1)
        first_w = fetched_word;
    end
    @(posedge clk);
    instr_done <= 1'b0;
    chk(passes, c + 32'h1);
    if (s)
      chk(held_instruction_reg, first_w);
    $display("repeat s=%0d count=%0d done", s, c);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #(25 * 20000);
    n_fail++;
    wrap_up();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {block_repeat_op, single_repeat_op, rel_mode, instr_done, count_wr, status_wr, nrst} = 7'h00;
    {rel_operand, reg_operand, op_pc, src_count, count_wr_data} = 136'h0;
    status_wr_data = 16'h0000;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    run(1'b0, 32'h0, 24'h1);
    run(1'b1, 32'h0, 24'h1);
    repeat (8)
    begin
      r = rnd();
      run(r[0], {29'h0, r[3:1]}, {22'h0, r[6:5]} + 24'h1);
    end
    count_wr <= 1'b1;
    count_wr_data <= 32'h3;
    @(posedge clk);
    {count_wr, op_pc, rel_mode, reg_operand, block_repeat_op} <= {1'b0, pc, 1'b0, pc, 1'b1};
    @(posedge clk);
    block_repeat_op <= 1'b0;
    repeat (5) @(posedge clk);
    instr_done <= 1'b1;
    repeat (6) @(posedge clk);
    chk(status_word[8], 1'b1);
    {instr_done, status_wr, status_wr_data} <= {2'h1, 16'h0000};
    @(posedge clk);
    {instr_done, status_wr} <= 2'h2;
    repeat (3) @(posedge clk);
    chk(status_word[8], 1'b0);
    chk(loop_count, 32'h3);
    {instr_done, count_wr, count_wr_data} <= {2'h1, 32'h0};
    @(posedge clk);
    {count_wr, status_wr, status_wr_data} <= {2'h1, 16'h0100};
    @(posedge clk);
    status_wr <= 1'b0;
    @(posedge clk);
    chk(status_word[8], 1'b0);
    wrap_up();
  end
endmodule // zero_overhead_loop_sequencer_tb_top
`default_nettype wire
